// file: pin_channel_defines.svh
`ifndef PIN_CHANNEL_DEFINES_SVH
`define PIN_CHANNEL_DEFINES_SVH

// ****************************************
// geometry
// ****************************************
`define NUM_CH 4
`define DATA_W 16
`define ADDR_W 16
`define REG_W 5
`define CNT_W 32

// ****************************************
// address word fields
// ****************************************
`define AB_REG_LSB 0
`define AB_CH_LSB 10
`define AB_COMMON 14
`define AB_BURST 15

// ****************************************
// channel register offsets
// ****************************************
`define OFF_STATUS 5'h00
`define OFF_CNT_LO 5'h01
`define OFF_CNT_HI 5'h02
`define OFF_STATIC 5'h03
`define OFF_DYNAMIC 5'h04
`define OFF_MEM_PTR 5'h05
`define OFF_MEM_FIRST 5'h06
`define OFF_COARSE0 5'h07
`define OFF_SLOT_STEP 5'h02
`define OFF_CAL0 5'h0e
`define OFF_CH_LAST 5'h12

// ****************************************
// status bits
// ****************************************
`define ST_LONG_EDGE 7
`define ST_ORDER 6
`define ST_OVERFLOW 5
`define ST_TOO_CLOSE 4
`define ST_FAIL_W 4
`define ST_W 8

// ****************************************
// static and dynamic bits
// ****************************************
`define SC_LEVEL_LOW 3
`define SC_LEVEL_HIGH 2
`define SC_TRISTATE 1
`define SC_ACTIVE 0
`define SC_W 4
`define DC_EDGE_EN 4
`define DC_ALT_CLK 3
`define DC_FAIL_MASK 2
`define DC_LOW_JITTER 1
`define DC_INC 0
`define DC_W 5

// ****************************************
// memory pointer fields
// ****************************************
`define MP_INDEX_W 8
`define MP_SEL_LSB 8
`define MP_SEL_W 2
`define MP_W 10

// ****************************************
// reset values
// ****************************************
`define RST_STATUS 8'h00
`define RST_STATIC 4'h0
`define RST_DYNAMIC 5'h00
`define RST_MEM_PTR 10'h000
`define RST_COUNT 32'h0000_0000
`define RST_DATA 16'h0000

// ****************************************
// channels that route the low jitter clock
// ****************************************
`define LJ_CH_MASK 4'hc

`endif

// file: pin_channel_pkg.sv
`include "pin_channel_defines.svh"

package pin_channel_pkg;

	// ****************************************
	// state of the register bank, apart from the fail counters
	// ****************************************
	typedef struct packed {
		logic stg_valid; // retimed request present
		logic stg_write; // retimed request is a write
		logic [`ADDR_W-1:0] stg_addr; // retimed address word
		logic [`DATA_W-1:0] stg_wdata; // retimed write data
		logic [`NUM_CH-1:0][`ST_W-1:0] status; // sticky errors and fails
		logic [`NUM_CH-1:0][`SC_W-1:0] force_bits; // static forcing
		logic [`NUM_CH-1:0][`DC_W-1:0] dyn_bits; // dynamic control, bit 0 unused
		logic [`NUM_CH-1:0] inc_pulse; // manual counter bump
		logic [`NUM_CH-1:0][`MP_W-1:0] mem_ptr; // index and advance select
		logic [`NUM_CH-1:0] level; // drive level held
		logic [`NUM_CH-1:0] enable; // driver enable held
		logic [`DATA_W-1:0] rdata; // read answer
		logic rvalid; // read answer strobe
	} csr_state_t;

endpackage

// file: fail_event_counter.sv
`timescale 1ns/10ps
`include "pin_channel_defines.svh"

// ****************************************
// fail counter with snapshot and preload
// ****************************************
module fail_event_counter #(
	parameter int CNT_W = `CNT_W,
	parameter int HALF_W = `DATA_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// increment
	input wire logic [2:0] inc_amt,
	// register access
	input wire logic low_read,
	input wire logic low_write,
	input wire logic high_write,
	input wire logic [HALF_W-1:0] wdata,
	// values
	output logic [CNT_W-1:0] count_q,
	output logic [CNT_W-1:0] hold_q
);

	// live count and holding register kept as one state word
	struct packed {
		logic [CNT_W-1:0] count; // live count
		logic [CNT_W-1:0] hold; // snapshot and preload halves
	} cnt_q, cnt_d;

	// counting, snapshot and preload
	always_comb
	begin
		cnt_d.count = cnt_q.count + CNT_W'(inc_amt);
		cnt_d.hold = cnt_q.hold;
		if (low_read)
		begin
			cnt_d.hold = cnt_q.count;
		end
		if (low_write)
		begin
			cnt_d.hold[HALF_W-1:0] = wdata;
		end
		// preload wins over a fail in the same cycle
		if (high_write)
		begin
			cnt_d.count = {wdata, cnt_q.hold[HALF_W-1:0]};
		end
	end

	// registers
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			cnt_q.count <= `RST_COUNT;
			cnt_q.hold <= `RST_COUNT;
		end
		else
		begin
			cnt_q <= cnt_d;
		end
	end

	// values seen by the register bank
	assign count_q = cnt_q.count;
	assign hold_q = cnt_q.hold;

endmodule

// file: pin_channel_csr_bank.sv
`timescale 1ns/10ps
`include "pin_channel_defines.svh"

// Behaviour
// - decode 0x00-0x12 per channel, rest elsewhere
// - status bit 7 on early counter reload
// - status bit 6 on out-of-order edges
// - status bit 5 on adder overflow
// - status bit 4 on nonincreasing vernier delay
// - status bits 3-0 accumulate slot fails
// - 32-bit counter adds up to four fails
// - low read snapshots, high read returns held
// - high write loads both halves into counter
// - static bits 3/2 force drive level
// - static bits 1/0 force driver enable
// - dynamic bit 4 switches edge generators
// - dynamic bit 3 selects alternate cycle clock
// - dynamic bit 2 blocks all fails
// - dynamic bit 1 routes jitter clock, ch2-3
// - writing dynamic bit 0 bumps counter once
// - pointer bits 7-0 index timing memories
// - pointer bits 9-8 pick auto-increment slot
// - pointer read shows incremented index
// - channel enables; write all, read ORed
// - write data retimed, one-cycle write

module pin_channel_csr_bank #(
	parameter int NUM_CH = `NUM_CH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// register bus from the bus interface
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [`DATA_W-1:0] req_wdata,
	output logic [`DATA_W-1:0] rdata,
	output logic rvalid,
	// timing memory port
	output logic [NUM_CH-1:0] mem_strobe,
	output logic mem_write,
	output logic [`REG_W-1:0] mem_offset,
	output logic [NUM_CH-1:0][`MP_INDEX_W-1:0] mem_index,
	output logic [`DATA_W-1:0] mem_wdata,
	input wire logic [NUM_CH-1:0][`DATA_W-1:0] mem_rdata,
	// edge generator events
	input wire logic [NUM_CH-1:0] err_long_edge,
	input wire logic [NUM_CH-1:0] err_order,
	input wire logic [NUM_CH-1:0] err_overflow,
	input wire logic [NUM_CH-1:0] err_too_close,
	input wire logic [NUM_CH-1:0][`ST_FAIL_W-1:0] fail_event,
	input wire logic [NUM_CH-1:0][`ST_FAIL_W-1:0] fail_mask_pattern,
	input wire logic [NUM_CH-1:0] compare_fail,
	// pattern data
	input wire logic [NUM_CH-1:0] pattern_level,
	input wire logic [NUM_CH-1:0] pattern_enable,
	input wire logic low_jitter_clock,
	// edge generator controls
	output logic [NUM_CH-1:0] edge_gen_enable,
	output logic [NUM_CH-1:0] alt_cycle_select,
	// pin drive
	output logic [NUM_CH-1:0] drive_level_out,
	output logic [NUM_CH-1:0] driver_enable_out
);

	// ****************************************
	// decoding helpers
	// ****************************************

	// offset holds a channel register
	function automatic logic in_channel_space(input logic [`REG_W-1:0] off);
		in_channel_space = (off <= `OFF_CH_LAST);
	endfunction

	// offset is the coarse or calibration register of the chosen slot
	function automatic logic advances_ptr(input logic [`REG_W-1:0] off,
		input logic [`MP_SEL_W-1:0] sel);
		logic [`REG_W-1:0] coarse;
		logic [`REG_W-1:0] cal;
		coarse = `OFF_COARSE0 + `REG_W'(sel) * `OFF_SLOT_STEP;
		cal = `OFF_CAL0 + `REG_W'(sel);
		advances_ptr = (off == coarse) || (off == cal);
	endfunction

	// count of ones in a fail nibble
	function automatic logic [2:0] ones(input logic [`ST_FAIL_W-1:0] v);
		ones = 3'h0;
		for (int i = 0; i < `ST_FAIL_W; i++)
		begin
			ones = ones + {2'h0, v[i]};
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	pin_channel_pkg::csr_state_t state_q; // registered state
	pin_channel_pkg::csr_state_t state_d; // next state

	logic [`REG_W-1:0] stg_off; // retimed register offset
	logic [NUM_CH-1:0] stg_sel; // channels enabled by the retimed request
	logic [NUM_CH-1:0][`ST_FAIL_W-1:0] fails_ok; // fails that count
	logic [NUM_CH-1:0][2:0] inc_amt; // counter increment per channel
	logic [NUM_CH-1:0][`CNT_W-1:0] count_live; // live counters
	logic [NUM_CH-1:0][`CNT_W-1:0] count_hold; // holding registers

	assign stg_off = state_q.stg_addr[`AB_REG_LSB +: `REG_W];
	assign stg_sel = state_q.stg_valid ? state_q.stg_addr[`AB_CH_LSB +: NUM_CH]
		: '0;

	// ****************************************
	// per-channel fail paths and counters
	// ****************************************
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_ch
			// masked, and dropped in alternate clock mode
			assign fails_ok[ch] = (state_q.dyn_bits[ch][`DC_FAIL_MASK]
				|| state_q.dyn_bits[ch][`DC_ALT_CLK]) ? '0
				: (fail_event[ch] & ~fail_mask_pattern[ch]);
			assign inc_amt[ch] = ones(fails_ok[ch])
				+ {2'h0, state_q.inc_pulse[ch]};

			fail_event_counter u_counter (
				.mclk(mclk),
				.nrst(nrst),
				.inc_amt(inc_amt[ch]),
				.low_read(stg_sel[ch] && !state_q.stg_write
					&& stg_off == `OFF_CNT_LO),
				.low_write(stg_sel[ch] && state_q.stg_write
					&& stg_off == `OFF_CNT_LO),
				.high_write(stg_sel[ch] && state_q.stg_write
					&& stg_off == `OFF_CNT_HI),
				.wdata(state_q.stg_wdata),
				.count_q(count_live[ch]),
				.hold_q(count_hold[ch])
			);
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic [`DATA_W-1:0] rd; // ORed read answer
		logic [`DATA_W-1:0] one; // one channel's answer
		logic hit; // channel takes this access
		rd = '0;
		one = '0;
		hit = 1'b0;
		state_d = state_q;

		// retime the request
		state_d.stg_valid = req_valid;
		state_d.stg_write = req_write;
		state_d.stg_addr = req_addr;
		state_d.stg_wdata = req_wdata;
		state_d.rvalid = state_q.stg_valid && !state_q.stg_write;
		state_d.inc_pulse = '0;

		for (int c = 0; c < NUM_CH; c++)
		begin
			hit = stg_sel[c] && in_channel_space(stg_off);

			// sticky error and fail capture
			state_d.status[c][`ST_LONG_EDGE] = state_q.status[c][`ST_LONG_EDGE]
				| err_long_edge[c];
			state_d.status[c][`ST_ORDER] = state_q.status[c][`ST_ORDER]
				| err_order[c];
			state_d.status[c][`ST_OVERFLOW] = state_q.status[c][`ST_OVERFLOW]
				| err_overflow[c];
			state_d.status[c][`ST_TOO_CLOSE] = state_q.status[c][`ST_TOO_CLOSE]
				| err_too_close[c];
			state_d.status[c][`ST_FAIL_W-1:0] = state_q.status[c][`ST_FAIL_W-1:0]
				| fails_ok[c];

			// read of status clears it, a new event in the same cycle survives
			if (hit && !state_q.stg_write && stg_off == `OFF_STATUS)
			begin
				state_d.status[c] = {err_long_edge[c], err_order[c], err_overflow[c],
					err_too_close[c], fails_ok[c]};
			end

			// register writes, every enabled channel
			if (hit && state_q.stg_write)
			begin
				unique case (stg_off)
					`OFF_STATIC:
					begin
						state_d.force_bits[c] = state_q.stg_wdata[`SC_W-1:0];
					end
					`OFF_DYNAMIC:
					begin
						state_d.dyn_bits[c] = {state_q.stg_wdata[`DC_W-1:1], 1'b0};
						state_d.inc_pulse[c] = state_q.stg_wdata[`DC_INC];
					end
					`OFF_MEM_PTR:
					begin
						state_d.mem_ptr[c] = state_q.stg_wdata[`MP_W-1:0];
					end
					default:
					begin
						state_d.mem_ptr[c] = state_q.mem_ptr[c];
					end
				endcase
			end

			// auto-increment after a memory access
			if (hit && advances_ptr(stg_off,
				state_q.mem_ptr[c][`MP_SEL_LSB +: `MP_SEL_W]))
			begin
				state_d.mem_ptr[c][`MP_INDEX_W-1:0] =
					state_q.mem_ptr[c][`MP_INDEX_W-1:0] + `MP_INDEX_W'(1);
			end

			// read answer of this channel
			one = '0;
			if (stg_off == `OFF_STATUS)
			begin
				one = `DATA_W'(state_q.status[c]);
			end
			else if (stg_off == `OFF_CNT_LO)
			begin
				one = count_live[c][`DATA_W-1:0];
			end
			else if (stg_off == `OFF_CNT_HI)
			begin
				one = count_hold[c][`CNT_W-1:`DATA_W];
			end
			else if (stg_off == `OFF_STATIC)
			begin
				one = `DATA_W'(state_q.force_bits[c]);
			end
			else if (stg_off == `OFF_DYNAMIC)
			begin
				one = `DATA_W'(state_q.dyn_bits[c]);
			end
			else if (stg_off == `OFF_MEM_PTR)
			begin
				one = `DATA_W'(state_q.mem_ptr[c]);
			end
			else if (stg_off >= `OFF_MEM_FIRST)
			begin
				one = mem_rdata[c];
			end
			if (hit && !state_q.stg_write)
			begin
				rd = rd | one;
			end

			// drive level: pattern when edges run, else forced or held
			if (state_q.dyn_bits[c][`DC_EDGE_EN])
			begin
				state_d.level[c] = pattern_level[c];
				state_d.enable[c] = pattern_enable[c];
			end
			else
			begin
				if (state_q.force_bits[c][`SC_LEVEL_LOW])
				begin
					state_d.level[c] = 1'b0;
				end
				else if (state_q.force_bits[c][`SC_LEVEL_HIGH])
				begin
					state_d.level[c] = 1'b1;
				end
				if (state_q.force_bits[c][`SC_TRISTATE])
				begin
					state_d.enable[c] = 1'b0;
				end
				else if (state_q.force_bits[c][`SC_ACTIVE])
				begin
					state_d.enable[c] = 1'b1;
				end
			end
		end

		// hold the answer until the next read
		if (state_q.stg_valid && !state_q.stg_write)
		begin
			state_d.rdata = rd;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			state_q.stg_valid <= 1'b0;
			state_q.stg_write <= 1'b0;
			state_q.stg_addr <= '0;
			state_q.stg_wdata <= `RST_DATA;
			state_q.status <= {NUM_CH{`RST_STATUS}};
			state_q.force_bits <= {NUM_CH{`RST_STATIC}};
			state_q.dyn_bits <= {NUM_CH{`RST_DYNAMIC}};
			state_q.inc_pulse <= '0;
			state_q.mem_ptr <= {NUM_CH{`RST_MEM_PTR}};
			state_q.level <= '0;
			state_q.enable <= '0;
			state_q.rdata <= `RST_DATA;
			state_q.rvalid <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata = state_q.rdata;
	assign rvalid = state_q.rvalid;

	// memory port follows the retimed request
	assign mem_write = state_q.stg_write;
	assign mem_offset = stg_off;
	assign mem_wdata = state_q.stg_wdata;

	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_out
			assign mem_strobe[ch] = stg_sel[ch] && stg_off >= `OFF_MEM_FIRST
				&& in_channel_space(stg_off);
			assign mem_index[ch] = state_q.mem_ptr[ch][`MP_INDEX_W-1:0];
			assign edge_gen_enable[ch] = state_q.dyn_bits[ch][`DC_EDGE_EN];
			assign alt_cycle_select[ch] = state_q.dyn_bits[ch][`DC_ALT_CLK];
			// clock passes unregistered so its edges keep their timing
			assign drive_level_out[ch] = ((((`LJ_CH_MASK >> ch) & 4'h1) != 4'h0)
				&& state_q.dyn_bits[ch][`DC_LOW_JITTER]) ? low_jitter_clock
				: state_q.level[ch];
			assign driver_enable_out[ch] = state_q.enable[ch];
		end
	endgenerate

endmodule

// file: pin_channel_csr_bank_sva.sv
`timescale 1ns/10ps
`include "pin_channel_defines.svh"

// ****************************************
// port checker
// ****************************************
module pin_channel_csr_bank_chk #(
	parameter int NUM_CH = 4
) (
	// clock, reset and bus
	input wire logic mclk,
	input wire logic nrst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [`DATA_W-1:0] req_wdata,
	input wire logic [`DATA_W-1:0] rdata,
	input wire logic rvalid,
	// memory port and pins
	input wire logic [NUM_CH-1:0] mem_strobe,
	input wire logic mem_write,
	input wire logic [`REG_W-1:0] mem_offset,
	input wire logic [`DATA_W-1:0] mem_wdata,
	input wire logic [NUM_CH-1:0][`MP_INDEX_W-1:0] mem_index,
	input wire logic [NUM_CH-1:0] pattern_level,
	input wire logic [NUM_CH-1:0] pattern_enable,
	input wire logic [NUM_CH-1:0] edge_gen_enable,
	input wire logic [NUM_CH-1:0] drive_level_out,
	input wire logic [NUM_CH-1:0] driver_enable_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	// read answered two edges after capture
	a_read_answer_time: assert property (req_valid && !req_write |-> ##2 rvalid)
		else $error("read not answered in time");
	a_reserved_reads_zero: assert property (req_valid && !req_write && req_addr[4:0] > 5'h12 |-> ##2 rdata == 16'h0000)
		else $error("reserved offset read nonzero");
	a_no_bank_zero: assert property (req_valid && !req_write && req_addr[13:10] == 4'h0 |-> ##2 rdata == 16'h0000)
		else $error("read without bank nonzero");
	a_rdata_holds_value: assert property (!rvalid |-> $stable(rdata))
		else $error("read data moved without strobe");
	// pattern data drives pins once edges run
	a_level_follows_pattern: assert property (edge_gen_enable[0] |=> drive_level_out[0] == $past(pattern_level[0]))
		else $error("drive level ignores pattern");
	a_enable_follows_pattern: assert property (edge_gen_enable[1] |=> driver_enable_out[1] == $past(pattern_enable[1]))
		else $error("driver enable ignores pattern");
	// memory strobes only for timing memory offsets
	a_strobe_in_range: assert property (|mem_strobe |-> $past(req_valid) && mem_offset >= 5'h06 && mem_offset <= 5'h12)
		else $error("memory strobe out of range");
	a_vernier_no_advance: assert property (mem_strobe[0] && (mem_offset inside {5'h06, 5'h08, 5'h0a, 5'h0c, 5'h12}) |=> $stable(mem_index[0]))
		else $error("pointer moved on vernier access");
	a_advance_by_one: assert property (mem_strobe[3] |=> mem_index[3] == $past(mem_index[3]) || mem_index[3] == $past(mem_index[3]) + 8'h01)
		else $error("pointer step not one");
	// memory port carries the retimed request
	a_mem_dir_match: assert property (|mem_strobe |-> mem_write == $past(req_write))
		else $error("memory direction not retimed request");
	a_mem_data_match: assert property (|mem_strobe |-> mem_wdata == $past(req_wdata))
		else $error("memory write data not retimed request");

	c_read: cover property (req_valid && !req_write ##2 rvalid);
	c_mem: cover property (mem_strobe[3]);
	c_edges: cover property (edge_gen_enable[0] ##1 edge_gen_enable[0]);
endmodule

bind pin_channel_csr_bank pin_channel_csr_bank_chk #(.NUM_CH(NUM_CH)) chk_u (.mclk(mclk), .nrst(nrst),
	.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
	.req_wdata(req_wdata), .rdata(rdata), .rvalid(rvalid), .mem_strobe(mem_strobe),
	.mem_write(mem_write), .mem_offset(mem_offset), .mem_wdata(mem_wdata), .mem_index(mem_index),
	.pattern_level(pattern_level), .pattern_enable(pattern_enable),
	.edge_gen_enable(edge_gen_enable), .drive_level_out(drive_level_out),
	.driver_enable_out(driver_enable_out));

// file: timing_mem_model.sv
`timescale 1ns/10ps
`include "pin_channel_defines.svh"

// ****************************************
// timing memory stand-in
// ****************************************
module timing_mem_model #(
	parameter int NUM_CH = 4
) (
	// memory port
	input wire logic mclk,
	input wire logic [NUM_CH-1:0] mem_strobe,
	input wire logic [`REG_W-1:0] mem_offset,
	input wire logic [NUM_CH-1:0][`MP_INDEX_W-1:0] mem_index,
	output logic [NUM_CH-1:0][`DATA_W-1:0] mem_rdata
);
	logic [`DATA_W-1:0] junk_q = 16'h5a5a; // filler, changes every cycle

	// filler moves so stale data never looks valid
	always @(posedge mclk)
		junk_q <= junk_q + 16'h1357;

	// answer carries offset and entry index
	always_comb
		for (int c = 0; c < NUM_CH; c++)
			mem_rdata[c] = mem_strobe[c] ? {3'h0, mem_offset, mem_index[c]} : junk_q;
endmodule

// file: test_pin_channel_csr_bank.sv
`timescale 1ns/10ps
`include "pin_channel_defines.svh"

module test_pin_channel_csr_bank;
	// ****************************************
	// signals
	// ****************************************
	logic mclk, nrst, req_valid, req_write, low_jitter_clock, rvalid, mem_write;
	logic [15:0] req_addr, req_wdata, rdata, mem_wdata, r;
	logic [4:0] mem_offset;
	logic [3:0] mem_strobe, err_long_edge, err_order, err_overflow, err_too_close, compare_fail;
	logic [3:0] pattern_level, pattern_enable, edge_gen_enable, alt_cycle_select;
	logic [3:0] drive_level_out, driver_enable_out;
	logic [3:0][7:0] mem_index;
	logic [3:0][15:0] mem_rdata;
	logic [3:0][3:0] fail_event, fail_mask_pattern;
	logic [31:0] v;
	int error_cnt, comparisons, cyc, c;

	pin_channel_csr_bank #(.NUM_CH(4)) dut_u (.mclk(mclk), .nrst(nrst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rdata(rdata),
		.rvalid(rvalid), .mem_strobe(mem_strobe), .mem_write(), .mem_offset(mem_offset),
		.mem_index(mem_index), .mem_wdata(), .mem_rdata(mem_rdata),
		.err_long_edge(err_long_edge), .err_order(err_order), .err_overflow(err_overflow),
		.err_too_close(err_too_close), .fail_event(fail_event),
		.fail_mask_pattern(fail_mask_pattern), .compare_fail(compare_fail),
		.pattern_level(pattern_level), .pattern_enable(pattern_enable),
		.low_jitter_clock(low_jitter_clock), .edge_gen_enable(edge_gen_enable),
		.alt_cycle_select(alt_cycle_select), .drive_level_out(drive_level_out),
		.driver_enable_out(driver_enable_out));

	timing_mem_model #(.NUM_CH(4)) mem_u (.mclk(mclk), .mem_strobe(mem_strobe),
		.mem_offset(mem_offset), .mem_index(mem_index), .mem_rdata(mem_rdata));

	// ****************************************
	// helpers
	// ****************************************
	// readable bits per offset
	function automatic logic [15:0] rmask(input logic [4:0] o);
		case (o)
			5'h03: return 16'h000f;
			5'h04: return 16'h001e;
			5'h05: return 16'h03ff;
			default: return 16'h0000;
		endcase
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one bus access; reads return their answer
	task automatic acc(input logic w, input logic [3:0] m, input logic [4:0] o,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge mclk);
		#1;
		req_valid = 1;
		req_write = w;
		req_addr = {2'h0, m, 5'h00, o};
		req_wdata = d;
		@(posedge mclk);
		#1;
		req_valid = 0;
		@(posedge mclk);
		#1;
		q = rdata;
		if (!w)
			chk({15'h0, rvalid}, 16'h0001);
	endtask

	task automatic rc(input logic [3:0] m, input logic [4:0] o, input logic [15:0] e);
		acc(0, m, o, 16'h0000, r);
		chk(r, e);
	endtask

	// one cycle of edge events and channel 0 fails
	task automatic ev(input logic [15:0] e, input logic [3:0] f, input logic [3:0] k);
		@(posedge mclk);
		#1;
		{err_long_edge, err_order, err_overflow, err_too_close} = e;
		fail_event[0] = f;
		fail_mask_pattern[0] = k;
		@(posedge mclk);
		#1;
		{err_long_edge, err_order, err_overflow, err_too_close} = 16'h0000;
		fail_event[0] = 4'h0;
	endtask

	task automatic close_out;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****************************************
	// clock and watchdog
	// ****************************************
	initial
	begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			close_out;
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		nrst = 0;
		req_valid = 0;
		req_write = 0;
		req_addr = 0;
		req_wdata = 0;
		low_jitter_clock = 0;
		{err_long_edge, err_order, err_overflow, err_too_close} = 0;
		fail_event = 0;
		fail_mask_pattern = 0;
		compare_fail = 0;
		pattern_level = 0;
		pattern_enable = 0;
		void'($urandom(32'h48ba));
		repeat (4) @(posedge mclk);
		#1;
		nrst = 1;
		// reset values and reserved space
		for (int o = 0; o < 6; o++)
			rc(4'hf, 5'(o), 16'h0000);
		rc(4'h1, 5'h13 + 5'($urandom_range(12, 0)), 16'h0000);
		$display("test reset done");
		// random register write and readback
		for (int k = 0; k < 12; k++)
		begin
			c = k % 4;
			v = $urandom;
			acc(1, 4'h1 << c, 5'h03 + 5'(k / 4), v[15:0], r);
			rc(4'h1 << c, 5'h03 + 5'(k / 4), v[15:0] & rmask(5'h03 + 5'(k / 4)));
		end
		acc(1, 4'hf, 5'h04, 16'h0000, r);
		$display("test regs done");
		// banks: ored reads, broadcast writes
		acc(1, 4'h1, 5'h03, 16'h0001, r);
		acc(1, 4'h2, 5'h03, 16'h0008, r);
		rc(4'h3, 5'h03, 16'h0009);
		rc(4'h0, 5'h03, 16'h0000);
		acc(1, 4'hf, 5'h03, 16'h0004, r);
		rc(4'h4, 5'h03, 16'h0004);
		$display("test banks done");
		// static forcing with edges off
		for (int k = 0; k < 4; k++)
		begin
			v = {28'h0, k[0] ? 4'h9 : 4'h6} ^ {28'h0, k[1] ? 4'hf : 4'h0};
			acc(1, 4'h1, 5'h03, v[15:0], r);
			repeat (2) @(posedge mclk);
			#1;
			chk({15'h0, drive_level_out[0]}, {15'h0, !v[3] && v[2]});
			chk({15'h0, driver_enable_out[0]}, {15'h0, !v[1] && v[0]});
		end
		$display("test force done");
		// counter preload, snapshot, bumps and fails
		for (int k = 0; k < 2; k++)
		begin
			v = k ? $urandom : 32'h0000_ffff;
			acc(1, 4'h1, 5'h01, v[15:0], r);
			acc(1, 4'h1, 5'h02, v[31:16], r);
			rc(4'h1, 5'h01, v[15:0]);
			rc(4'h1, 5'h02, v[31:16]);
			acc(1, 4'h1, 5'h04, 16'h0001, r);
			v = v + 32'h1;
			rc(4'h1, 5'h01, v[15:0]);
			rc(4'h1, 5'h02, v[31:16]);
		end
		ev(16'h0000, 4'hb, 4'h2);
		v = v + 32'h2;
		rc(4'h1, 5'h01, v[15:0]);
		rc(4'h1, 5'h00, 16'h0009);
		acc(1, 4'h1, 5'h04, 16'h0004, r);
		ev(16'h0000, 4'hf, 4'h0);
		rc(4'h1, 5'h01, v[15:0]);
		rc(4'h1, 5'h00, 16'h0000);
		acc(1, 4'h1, 5'h04, 16'h0008, r);
		chk({15'h0, alt_cycle_select[0]}, 16'h0001);
		ev(16'h0000, 4'hf, 4'h0);
		rc(4'h1, 5'h01, v[15:0]);
		acc(1, 4'h1, 5'h04, 16'h0000, r);
		$display("test counter done");
		// each edge error flag, then clear on read
		for (int i = 0; i < 4; i++)
		begin
			c = $urandom_range(3, 0);
			ev(16'h0001 << (4 * (3 - i) + c), 4'h0, 4'h0);
			rc(4'h1 << c, 5'h00, 16'h0080 >> i);
			rc(4'h1 << c, 5'h00, 16'h0000);
		end
		$display("test flags done");
		// memory pointer auto-increment on channel 3
		acc(1, 4'h8, 5'h05, 16'h0210, r);
		rc(4'h8, 5'h0b, 16'h0b10);
		rc(4'h8, 5'h05, 16'h0211);
		acc(1, 4'h8, 5'h10, 16'h1234, r);
		acc(1, 4'h8, 5'h07, 16'h1234, r);
		// vernier access on two channels must not move the channel 3 pointer
		acc(1, 4'h9, 5'h06, 16'h0abc, r);
		rc(4'h8, 5'h05, 16'h0212);
		$display("test pointer done");
		// edges on, then low jitter passthrough
		acc(1, 4'h3, 5'h04, 16'h0010, r);
		chk({12'h0, edge_gen_enable}, 16'h0003);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge mclk);
			#1;
			pattern_level = 4'($urandom);
			pattern_enable = 4'($urandom);
		end
		acc(1, 4'h4, 5'h04, 16'h0002, r);
		low_jitter_clock = 1;
		#1;
		chk({15'h0, drive_level_out[2]}, 16'h0001);
		low_jitter_clock = 0;
		#1;
		chk({15'h0, drive_level_out[2]}, 16'h0000);
		$display("test edges done");
		close_out;
	end
endmodule
